//--- rtl/uic_irq_ctrl.sv
`timescale 1ns/1ns
module uic_irq_ctrl #(
  parameter int LEVEL_W = 5
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic [2:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic [7:0]                rx_data,
  input  wire logic [7:0]                line_status,
  input  wire logic [7:0]                modem_status,
  input  wire logic [LEVEL_W-1:0]        rx_level,
  input  wire logic                      tx_empty,
  input  wire logic                      tx_full,
  input  wire logic                      bit_tick,
  input  wire uic_pkg::uic_rx_event_type rx_event,
  input  wire logic [3:0]                modem_change,
  input  wire uic_pkg::uic_enh_type      enh,
  input  wire logic                      rts_level,
  input  wire logic                      cts_pin,
  output logic                           irq,
  output logic                           fifo_enable,
  output logic                           rx_fifo_clear,
  output logic                           tx_fifo_clear,
  output logic                           rx_hold_read,
  output logic                           tx_hold_write,
  output logic                           dma_mode,
  output logic      [1:0]                word_len,
  output logic                           sleep_enable,
  output logic                           rx_ready_pin_n,
  output logic                           tx_ready_pin_n
);
  import uic_pkg::*;

  // trigger level decode, used by the irq and by the rx ready pin
  function automatic logic [LEVEL_W-1:0] trig_level(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = UIC_TRIG_1;
    unique case (sel)
      2'h0: lvl = UIC_TRIG_1;
      2'h1: lvl = UIC_TRIG_4;
      2'h2: lvl = UIC_TRIG_8;
      2'h3: lvl = UIC_TRIG_14;
    endcase
    return LEVEL_W'(lvl);
  endfunction

  // time-out length in bit times for a word length code
  function automatic logic [5:0] timeout_bits(input logic [1:0] wl);
    logic [5:0] frame;
    frame = UIC_WORD_BASE + {4'h0, wl} + UIC_FRAME_EXTRA;
    return 6'(frame * UIC_TO_CHARS) + UIC_TO_EXTRA;
  endfunction

  // registers
  logic [7:0]         irq_enable_reg;
  logic [7:0]         line_ctrl_reg;
  logic [1:0]         trig_sel;
  logic               line_pend;
  logic               timeout_pend;
  logic               tx_pend;
  logic               modem_pend;
  logic               xoff_pend;
  logic               special_pend;
  logic               flow_pend;
  logic [5:0]         to_count;
  logic               tx_empty_q;
  logic               tx_ie_q;
  logic               rts_q;
  logic               cts_meta;
  logic               cts_sync;
  logic               cts_q;

  // bus decode
  wire                wr_data    = reg_wr && reg_addr == UIC_ADDR_DATA;
  wire                wr_ie      = reg_wr && reg_addr == UIC_ADDR_IRQ_ENABLE;
  wire                wr_fifo    = reg_wr && reg_addr == UIC_ADDR_STATUS_FIFO;
  wire                wr_lc      = reg_wr && reg_addr == UIC_ADDR_LINE_CTRL;
  wire                rd_data    = reg_rd && reg_addr == UIC_ADDR_DATA;
  wire                rd_status  = reg_rd && reg_addr == UIC_ADDR_STATUS_FIFO;
  wire                rd_line    = reg_rd && reg_addr == UIC_ADDR_LINE_STATUS;
  wire                rd_modem   = reg_rd && reg_addr == UIC_ADDR_MODEM_STAT;
  wire                fifo_set   = wr_fifo && reg_wdata[UIC_FC_ENABLE];

  // effective enables; upper ones need enhanced mode
  wire [7:0]          ie_eff     = {irq_enable_reg[7:4] & {4{enh.enhanced}},
                                    irq_enable_reg[3:0]};

  // source conditions
  wire [LEVEL_W-1:0]  trig       = trig_level(trig_sel);
  wire                rx_nempty  = rx_level != '0;
  wire                rx_at_trig = rx_level >= trig;
  wire                rx_cond    = fifo_enable ? rx_at_trig : rx_nempty;
  wire                to_hit     = to_count >= timeout_bits(line_ctrl_reg[1:0]);
  wire                cts_rise   = cts_sync && !cts_q && enh.auto_cts;
  wire                rts_rise   = rts_level && !rts_q && enh.auto_rts;

  // enabled pending sources
  wire                act_line   = line_pend && ie_eff[UIC_IE_LINE];
  wire                act_to     = timeout_pend && ie_eff[UIC_IE_RX];
  wire                act_rx     = rx_cond && ie_eff[UIC_IE_RX];
  wire                act_tx     = tx_pend && ie_eff[UIC_IE_TX];
  wire                act_modem  = modem_pend && ie_eff[UIC_IE_MODEM];
  wire                act_xoff   = (xoff_pend || special_pend) && ie_eff[UIC_IE_XOFF];
  wire                act_flow   = flow_pend && (ie_eff[UIC_IE_RTS] || ie_eff[UIC_IE_CTS]);
  wire                any_act    = act_line || act_to || act_rx || act_tx ||
                                   act_modem || act_xoff || act_flow;

  // priority encode, highest pending source only
  wire [5:0]          isr_code   = act_line  ? UIC_CODE_LINE    :
                                   act_to    ? UIC_CODE_TIMEOUT :
                                   act_rx    ? UIC_CODE_RX      :
                                   act_tx    ? UIC_CODE_TX      :
                                   act_modem ? UIC_CODE_MODEM   :
                                   act_xoff  ? UIC_CODE_XOFF    :
                                   act_flow  ? UIC_CODE_FLOW    :
                                               UIC_CODE_NONE;
  wire [7:0]          isr_byte   = {{2{fifo_enable}}, isr_code};
  wire                isr_tx     = rd_status && isr_code == UIC_CODE_TX;
  wire                isr_xoff   = rd_status && isr_code == UIC_CODE_XOFF;

  // set and clear terms; a set in the clearing cycle wins, except the time-out, where a data read wins
  wire                set_line   = rx_event.overrun || rx_event.pop_err;
  wire                set_tx     = (tx_empty && !tx_empty_q) ||
                                   (tx_empty && irq_enable_reg[UIC_IE_TX] && !tx_ie_q);
  wire                set_modem  = |modem_change;
  wire                set_flow   = cts_rise || rts_rise;
  wire                next_line  = set_line || (line_pend && !rd_line);
  wire                next_to    = (to_hit && rx_nempty && !rx_event.push && !rd_data) ||
                                   (timeout_pend && !rd_data);
  wire                next_tx    = set_tx ||
                                   (tx_pend && !isr_tx && !wr_data);
  wire                next_modem = set_modem || (modem_pend && !rd_modem);
  wire                next_xoff  = rx_event.xoff ||
                                   (xoff_pend && !isr_xoff && !rx_event.xon);
  wire                next_spec  = rx_event.special ||
                                   (special_pend && !isr_xoff && !rx_event.push);
  wire                next_flow  = set_flow || (flow_pend && !rd_modem);

  // time-out counter: restarts on any fifo activity, holds at expiry
  wire                to_restart = rx_event.push || rd_data || !rx_nempty;
  wire [5:0]          next_count = to_restart ? 6'h00 :
                                   (bit_tick && !to_hit) ? to_count + 6'h01 : to_count;

  // read data mux
  wire [7:0]          next_rdata = rd_data   ? rx_data        :
                                   rd_status ? isr_byte       :
                                   (reg_rd && reg_addr == UIC_ADDR_IRQ_ENABLE) ? irq_enable_reg :
                                   (reg_rd && reg_addr == UIC_ADDR_LINE_CTRL)  ? line_ctrl_reg  :
                                   rd_line   ? line_status    :
                                   rd_modem  ? modem_status   : 8'h00;

  // ready pins, active low; dma mode uses trigger and room
  wire                next_rxp_n = dma_mode ? !(rx_at_trig || timeout_pend) : !rx_nempty;
  wire                next_txp_n = dma_mode ? tx_full : !tx_empty;

  // cts pin synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cts_meta <= 1'b0;
      cts_sync <= 1'b0;
    end else begin
      cts_meta <= cts_pin;
      cts_sync <= cts_meta;
    end
  end

  // software visible control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_enable_reg <= UIC_IRQ_ENABLE_RST;
      line_ctrl_reg  <= UIC_LINE_CTRL_RST;
      fifo_enable    <= 1'b0;
      dma_mode       <= 1'b0;
      trig_sel       <= UIC_TRIG_RST;
    end else begin
      if (wr_ie) begin
        irq_enable_reg <= reg_wdata;
      end
      if (wr_lc) begin
        line_ctrl_reg <= reg_wdata;
      end
      if (wr_fifo) begin
        fifo_enable <= reg_wdata[UIC_FC_ENABLE];
      end
      if (fifo_set) begin
        dma_mode <= reg_wdata[UIC_FC_DMA];
        trig_sel <= reg_wdata[UIC_FC_TRIG_LO +: 2];
      end
    end
  end

  // line status pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_pend <= 1'b0;
    end else begin
      line_pend <= next_line;
    end
  end

  // receive time-out pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timeout_pend <= 1'b0;
    end else begin
      timeout_pend <= next_to;
    end
  end

  // transmit ready pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_pend <= 1'b0;
    end else begin
      tx_pend <= next_tx;
    end
  end

  // modem change pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modem_pend <= 1'b0;
    end else begin
      modem_pend <= next_modem;
    end
  end

  // xoff match pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xoff_pend <= 1'b0;
    end else begin
      xoff_pend <= next_xoff;
    end
  end

  // special character pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      special_pend <= 1'b0;
    end else begin
      special_pend <= next_spec;
    end
  end

  // flow pin rise pending, shared by rts and cts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flow_pend <= 1'b0;
    end else begin
      flow_pend <= next_flow;
    end
  end

  // bit times since the last fifo activity
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      to_count <= 6'h00;
    end else begin
      to_count <= next_count;
    end
  end

  // tx empty history; starts high so an idle empty fifo gives no false edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_empty_q <= 1'b1;
    end else begin
      tx_empty_q <= tx_empty;
    end
  end

  // tx enable history for enable-while-empty
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_ie_q <= 1'b0;
    end else begin
      tx_ie_q <= irq_enable_reg[UIC_IE_TX];
    end
  end

  // rts level history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rts_q <= 1'b0;
    end else begin
      rts_q <= rts_level;
    end
  end

  // synchronised cts history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cts_q <= 1'b0;
    end else begin
      cts_q <= cts_sync;
    end
  end

  // read data and holding register pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata     <= 8'h00;
      rx_hold_read  <= 1'b0;
      tx_hold_write <= 1'b0;
    end else begin
      reg_rdata     <= next_rdata;
      rx_hold_read  <= rd_data;
      tx_hold_write <= wr_data;
    end
  end

  // interrupt output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= any_act;
    end
  end

  // fifo reset pulses, one cycle each
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
    end else begin
      rx_fifo_clear <= fifo_set && reg_wdata[UIC_FC_RX_RST];
      tx_fifo_clear <= fifo_set && reg_wdata[UIC_FC_TX_RST];
    end
  end

  // word length and sleep copies
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_len     <= 2'h0;
      sleep_enable <= 1'b0;
    end else begin
      word_len     <= line_ctrl_reg[1:0];
      sleep_enable <= ie_eff[UIC_IE_SLEEP];
    end
  end

  // ready pins, idle high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_ready_pin_n <= 1'b1;
      tx_ready_pin_n <= 1'b1;
    end else begin
      rx_ready_pin_n <= next_rxp_n;
      tx_ready_pin_n <= next_txp_n;
    end
  end

endmodule

//--- rtl/uic_pkg.sv
package uic_pkg;

  // register indices on the local register port
  localparam logic [2:0] UIC_ADDR_DATA        = 3'h0; // rx holding read, tx holding write
  localparam logic [2:0] UIC_ADDR_IRQ_ENABLE  = 3'h1;
  localparam logic [2:0] UIC_ADDR_STATUS_FIFO = 3'h2; // irq status read, fifo control write
  localparam logic [2:0] UIC_ADDR_LINE_CTRL   = 3'h3;
  localparam logic [2:0] UIC_ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] UIC_ADDR_MODEM_STAT  = 3'h6;

  // reset values
  localparam logic [7:0] UIC_IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] UIC_LINE_CTRL_RST  = 8'h00;
  localparam logic [1:0] UIC_TRIG_RST       = 2'h0;

  // field positions
  localparam int UIC_IE_RX      = 0;
  localparam int UIC_IE_TX      = 1;
  localparam int UIC_IE_LINE    = 2;
  localparam int UIC_IE_MODEM   = 3;
  localparam int UIC_IE_SLEEP   = 4;
  localparam int UIC_IE_XOFF    = 5;
  localparam int UIC_IE_RTS     = 6;
  localparam int UIC_IE_CTS     = 7;
  localparam int UIC_FC_ENABLE  = 0;
  localparam int UIC_FC_RX_RST  = 1;
  localparam int UIC_FC_TX_RST  = 2;
  localparam int UIC_FC_DMA     = 3;
  localparam int UIC_FC_TRIG_LO = 6;

  // interrupt status codes, bits 5..0
  localparam logic [5:0] UIC_CODE_LINE    = 6'h06;
  localparam logic [5:0] UIC_CODE_TIMEOUT = 6'h0C;
  localparam logic [5:0] UIC_CODE_RX      = 6'h04;
  localparam logic [5:0] UIC_CODE_TX      = 6'h02;
  localparam logic [5:0] UIC_CODE_MODEM   = 6'h00;
  localparam logic [5:0] UIC_CODE_XOFF    = 6'h10;
  localparam logic [5:0] UIC_CODE_FLOW    = 6'h20;
  localparam logic [5:0] UIC_CODE_NONE    = 6'h01;

  // receive trigger levels
  localparam logic [4:0] UIC_TRIG_1  = 5'h01;
  localparam logic [4:0] UIC_TRIG_4  = 5'h04;
  localparam logic [4:0] UIC_TRIG_8  = 5'h08;
  localparam logic [4:0] UIC_TRIG_14 = 5'h0E;

  // receive time-out: four characters plus twelve bits
  localparam logic [5:0] UIC_TO_CHARS     = 6'h04;
  localparam logic [5:0] UIC_TO_EXTRA     = 6'h0C;
  localparam logic [5:0] UIC_FRAME_EXTRA  = 6'h02; // start and one stop bit
  localparam logic [5:0] UIC_WORD_BASE    = 6'h05;

  // events from the receive datapath, one-cycle pulses
  typedef struct packed {
    logic       push;     // character written into the receive fifo
    logic       pop_err;  // character with parity, framing or break read out
    logic       overrun;  // character lost on a full fifo
    logic       xoff;     // xoff character matched
    logic       xon;      // xon character matched
    logic       special;  // special character matched
  } uic_rx_event_type;

  // enhanced feature controls
  typedef struct packed {
    logic       enhanced; // unlocks upper enable and status bits
    logic       auto_rts;
    logic       auto_cts;
  } uic_enh_type;

endpackage

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import uic_pkg::*;
  logic             clk, reset, reg_wr, reg_rd, tx_empty, tx_full, bit_tick, rts_level, cts_pin;
  logic             irq, fifo_enable, rx_fifo_clear, tx_fifo_clear, rx_hold_read, dma_mode;
  logic             tx_hold_write, sleep_enable, rx_ready_pin_n, tx_ready_pin_n;
  logic [2:0]       reg_addr;
  logic [7:0]       reg_wdata, reg_rdata, rx_data, line_status, modem_status, rv;
  logic [4:0]       rx_level;
  logic [3:0]       modem_change;
  logic [1:0]       word_len;
  uic_rx_event_type rx_event;
  uic_enh_type      enh;
  int               mismatches, tests_run, k, t;

  uic_irq_ctrl #(.LEVEL_W(5)) u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_data, .line_status, .modem_status, .rx_level, .tx_empty, .tx_full,
    .bit_tick, .rx_event, .modem_change, .enh, .rts_level, .cts_pin, .irq, .fifo_enable,
    .rx_fifo_clear, .tx_fifo_clear, .rx_hold_read, .tx_hold_write, .dma_mode, .word_len,
    .sleep_enable, .rx_ready_pin_n, .tx_ready_pin_n);
  uic_host_model u_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  // free-running 25 MHz clock
  always #20 clk = ~clk;

  // trigger level for each select code
  function automatic int trig(input logic [1:0] c);
    case (c)
      2'h0: return 1;
      2'h1: return 4;
      2'h2: return 8;
      default: return 14;
    endcase
  endfunction
  // compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  // settle two cycles, then read and compare
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    repeat (2) @(posedge clk);
    u_host.rd(a, d);
    chk(n, e, d);
  endtask
  // one-cycle receive event
  task automatic ev(input logic [5:0] e);
    @(posedge clk);
    rx_event <= uic_rx_event_type'(e);
    @(posedge clk);
    rx_event <= '0;
  endtask
  task automatic done(input string n);
    $display("test %s done, %0d checks", n, tests_run);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #(40 * 5000);
    mismatches++;
    summarize();
  end

  // main sequence
  initial begin
    k = $urandom(52138);
    {clk, tx_empty, tx_full, bit_tick, rts_level, cts_pin} = '0;
    {rx_level, modem_change, rx_event, enh} = '0;
    reset = 1'b1;
    rx_data = 8'($urandom);
    line_status = 8'($urandom);
    modem_status = 8'($urandom);
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rdc(3'h1, 8'h00, "irq_enable reset");
    rdc(3'h3, 8'h00, "line_ctrl reset");
    rdc(3'h2, 8'h01, "status reset");
    rdc(3'h7, 8'h00, "unmapped");
    rv = 8'($urandom);
    enh.enhanced <= 1'b1;
    u_host.wr(3'h1, rv);
    rdc(3'h1, rv, "irq_enable rw");
    chk("sleep", {7'h00, rv[4]}, {7'h00, sleep_enable});
    enh.enhanced <= 1'b0;
    u_host.wr(3'h1, 8'h00);
    done("reset");
    u_host.wr(3'h1, 8'h02);
    rdc(3'h2, 8'h01, "tx full");
    tx_empty <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq tx", 8'h01, {7'h00, irq});
    rdc(3'h2, 8'h02, "tx status");
    repeat (2) @(posedge clk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    u_host.wr(3'h1, 8'h00);
    u_host.wr(3'h1, 8'h02);
    repeat (4) @(posedge clk);
    chk("irq enable empty", 8'h01, {7'h00, irq});
    u_host.wr(3'h0, 8'($urandom));
    rdc(3'h2, 8'h01, "tx written");
    u_host.wr(3'h1, 8'h00);
    done("tx");
    u_host.wr(3'h1, 8'h0E);
    @(posedge clk);
    modem_change <= 4'h1 << ($urandom % 4);
    @(posedge clk);
    modem_change <= 4'h0;
    for (k = 0; k < 2; k++) begin
      ev(k ? 6'h10 : 6'h08);
      rdc(3'h2, 8'h06, "line first");
      rdc(3'h5, line_status, "line status");
    end
    rdc(3'h2, 8'h02, "tx queued");
    rdc(3'h2, 8'h00, "modem queued");
    rdc(3'h6, modem_status, "modem status");
    rdc(3'h2, 8'h01, "queue empty");
    chk("irq idle", 8'h00, {7'h00, irq});
    done("priority");
    u_host.wr(3'h1, 8'h01);
    for (k = 0; k < 4; k++) begin
      u_host.wr(3'h2, {2'(k), 6'h01});
      t = trig(2'(k));
      rx_level <= 5'($urandom % t);
      rdc(3'h2, 8'hC1, "below trigger");
      rx_level <= 5'(t + $urandom % (17 - t));
      rdc(3'h2, 8'hC4, "at trigger");
      rx_level <= 5'(t - 1);
      rdc(3'h2, 8'hC1, "drained");
    end
    done("trigger");
    rx_level <= 5'h02;
    bit_tick <= 1'b1;
    ev(6'h20);
    repeat (25) @(posedge clk);
    rdc(3'h2, 8'hC1, "before timeout");
    repeat (20) @(posedge clk);
    rdc(3'h2, 8'hCC, "timeout");
    rdc(3'h0, rx_data, "rx data");
    rdc(3'h2, 8'hC1, "timeout cleared");
    bit_tick <= 1'b0;
    rx_level <= 5'h00;
    done("timeout");
    u_host.wr(3'h1, 8'h20);
    ev(6'h04);
    rdc(3'h2, 8'hC1, "xoff locked");
    enh.enhanced <= 1'b1;
    ev(6'h04);
    rdc(3'h2, 8'hD0, "xoff");
    rdc(3'h2, 8'hC1, "xoff read");
    ev(6'h04);
    ev(6'h02);
    rdc(3'h2, 8'hC1, "xon");
    ev(6'h01);
    ev(6'h20);
    rdc(3'h2, 8'hC1, "special next");
    done("xoff");
    u_host.wr(3'h1, 8'hC0);
    for (k = 0; k < 2; k++) begin
      enh.auto_rts <= (k == 0);
      enh.auto_cts <= (k == 1);
      @(posedge clk);
      if (k == 0) rts_level <= 1'b1;
      else cts_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(3'h2, 8'hE0, "flow");
      rdc(3'h6, modem_status, "modem read");
      rdc(3'h2, 8'hC1, "flow cleared");
    end
    done("flow");
    u_host.wr(3'h2, 8'h09);
    tx_full <= 1'b1;
    rdc(3'h2, 8'hC1, "dma status");
    chk("dma on", 8'h01, {7'h00, dma_mode});
    u_host.wr(3'h2, 8'h00);
    tx_full <= 1'b0;
    rdc(3'h2, 8'h01, "fifo off");
    chk("dma kept", 8'h01, {7'h00, dma_mode});
    u_host.wr(3'h2, 8'h07);
    rdc(3'h2, 8'hC1, "fifo reset");
    chk("dma off", 8'h00, {7'h00, dma_mode});
    done("fifo control");
    for (k = 0; k < 4; k++) begin
      rv = {1'b0, 5'($urandom), 2'(k)};
      u_host.wr(3'h3, rv);
      rdc(3'h3, rv, "line_ctrl rw");
      chk("word_len", 8'(k), {6'h00, word_len});
    end
    done("word length");
    summarize();
  end
endmodule

//--- tb/uic_host_model.sv
`timescale 1ns/1ns
module uic_host_model (
  input  wire logic       clk,
  output logic      [2:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // bus idle from time zero
  initial begin
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one-cycle write strobe beside address and data
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

//--- tb/uic_irq_ctrl_asserts.sv
`timescale 1ns/1ns
module uic_irq_ctrl_asserts
  import uic_pkg::*;
#(
  parameter int LEVEL_W = 5
) (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic [2:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic               tx_empty,
  input wire logic               tx_full,
  input wire uic_enh_type        enh,
  input wire logic               fifo_enable,
  input wire logic               rx_fifo_clear,
  input wire logic               tx_fifo_clear,
  input wire logic               rx_hold_read,
  input wire logic               tx_hold_write,
  input wire logic               dma_mode,
  input wire logic [1:0]         word_len,
  input wire logic               sleep_enable,
  input wire logic               rx_ready_pin_n,
  input wire logic               tx_ready_pin_n
);
  // all checks share the one clock and its reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // read port and status byte
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero without a read");
  status_code_a: assert property ($past(reg_rd && reg_addr == 3'h2) |->
    reg_rdata[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
    else $error("status code outside the priority table");
  status_top_a: assert property ($past(reg_rd && reg_addr == 3'h2) |->
    reg_rdata[7:6] == {2{$past(fifo_enable)}}) else $error("status top bits wrong");
  hold_read_a: assert property (rx_hold_read == $past(reg_rd && reg_addr == 3'h0))
    else $error("holding read pulse wrong");
  hold_write_a: assert property (tx_hold_write == $past(reg_wr && reg_addr == 3'h0))
    else $error("holding write pulse wrong");
  // fifo control and line control writes, sleep gate
  fifo_enable_a: assert property ($past(reg_wr && reg_addr == 3'h2) |->
    fifo_enable == $past(reg_wdata[0])) else $error("fifo enable not written");
  dma_refused_a: assert property ($past(reg_wr && reg_addr == 3'h2 && !reg_wdata[0]) |->
    $stable(dma_mode)) else $error("dma bit taken without fifo enable");
  fifo_clear_a: assert property ($past(reg_wr && reg_addr == 3'h2 && reg_wdata[0]) |->
    {tx_fifo_clear, rx_fifo_clear} == $past(reg_wdata[2:1]) ##1
    !(tx_fifo_clear || rx_fifo_clear)) else $error("fifo clear pulse wrong");
  word_len_a: assert property ($past(reg_wr && reg_addr == 3'h3, 2) |->
    word_len == $past(reg_wdata[1:0], 2)) else $error("word length not copied");
  sleep_gate_a: assert property (sleep_enable |-> $past(enh.enhanced))
    else $error("sleep enable without enhanced mode");
  // ready pins, normal and dma shapes for tx, normal shape only for rx
  tx_pin_a: assert property (tx_ready_pin_n ==
    ($past(dma_mode) ? $past(tx_full) : !$past(tx_empty))) else $error("tx ready pin wrong");
  rx_pin_a: assert property (!$past(dma_mode) |->
    rx_ready_pin_n == ($past(rx_level) == '0)) else $error("rx ready pin wrong");
  // main scenarios reached
  cover property ($past(reg_rd && reg_addr == 3'h2) && reg_rdata[5:0] == 6'h0C);
  cover property ($past(reg_rd && reg_addr == 3'h2) && reg_rdata[5:0] == 6'h20);
  cover property (fifo_enable && rx_fifo_clear && tx_fifo_clear);
endmodule

bind uic_irq_ctrl uic_irq_ctrl_asserts #(.LEVEL_W(LEVEL_W)) u_asserts (
  .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_level,
  .tx_empty, .tx_full, .enh, .fifo_enable, .rx_fifo_clear, .tx_fifo_clear, .tx_hold_write,
  .rx_hold_read, .dma_mode, .word_len, .sleep_enable, .rx_ready_pin_n, .tx_ready_pin_n
);
